/* File: hcie_flag.sv */
// One sticky status flag with its enable gate
module hcie_flag (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic event_in,
   input wire logic clear_in,
   input wire logic enable_in,
   output logic flag_q,
   output logic gated
);
   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= event_in | (flag_q & ~clear_in);
      end
   end
   assign gated = flag_q & enable_in;
endmodule // hcie_flag

/* File: hcie_host.sv */
// Host processor model issuing commands and data words
module hcie_host (
   input wire logic clk_sys,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic wr_valid,
   output logic [15:0] wr_data,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid
);
   timeunit 1ns / 1ps;
   initial {cmd_valid, cmd_code, wr_valid, wr_data} = 26'h000_0000;
   task automatic xfer(input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_code = c;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      if (c[7]) begin
         wr_valid = 1'b1;
         wr_data = d;
         @(negedge clk_sys);
         wr_valid = 1'b0;
         wr_data = ~d; // Released data shows the inverse
      end
      for (int n = 0; n < 4 && rd_valid !== 1'b1; n++) @(negedge clk_sys);
      q = rd_data;
   endtask
endmodule // hcie_host

/* File: hcie_irq_enable.sv */
// Per-source interrupt enable and request logic behind the command port
module hcie_irq_enable (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic wr_valid,
   input wire logic [15:0] wr_data,
   output logic [15:0] rd_data,
   output logic rd_valid,
   input wire logic [15:0] hw_config_reg,
   input wire logic clock_ready_event,
   input wire logic suspended_event,
   input wire logic op_reg_event,
   input wire logic end_of_transfer_int,
   input wire logic end_of_transfer_ext,
   input wire logic async_list_event,
   input wire logic sof_event,
   output logic irq_q
);
   // ***************************************
   // Command tracking
   // ***************************************
   logic [7:0] cmd_q;
   logic [15:0] enable_q;
   logic [15:0] enable_d;
   logic [6:0] events;
   logic [6:0] flags;
   logic [6:0] gated;
   logic [6:0] clear_bits;
   wire wr_enable = wr_valid & (cmd_q == hcie_pkg::CMD_ENABLE_WR);
   wire wr_status = wr_valid & (cmd_q == hcie_pkg::CMD_STATUS_WR);
   wire rd_enable = cmd_valid & (cmd_code == hcie_pkg::CMD_ENABLE_RD);
   wire rd_status = cmd_valid & (cmd_code == hcie_pkg::CMD_STATUS_RD);
   wire irq_d;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cmd_q <= 8'h00;
      end else if (cmd_valid) begin
         cmd_q <= cmd_code;
      end
   end

   // ***************************************
   // Enable register
   // ***************************************
   assign enable_d = wr_enable ? (wr_data & hcie_pkg::ENABLE_MASK) : enable_q;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         enable_q <= hcie_pkg::ENABLE_RESET;
      end else begin
         enable_q <= enable_d;
      end
   end

   // ***************************************
   // Status flags, position for position
   // ***************************************
   assign events[hcie_pkg::BIT_SOF] = sof_event;
   assign events[hcie_pkg::BIT_ASYNC] = async_list_event;
   assign events[hcie_pkg::BIT_EOT] = end_of_transfer_int | end_of_transfer_ext;
   assign events[3] = 1'b0;
   assign events[hcie_pkg::BIT_OPREG] = op_reg_event;
   assign events[hcie_pkg::BIT_SUSP] = suspended_event;
   assign events[hcie_pkg::BIT_CLKRDY] = clock_ready_event;
   assign clear_bits = wr_status ? wr_data[6:0] : 7'h00;

   genvar gi;
   generate
      for (gi = 0; gi < hcie_pkg::NUM_SRC; gi++) begin : g_src
         hcie_flag u_flag (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .event_in(events[gi]),
            .clear_in(clear_bits[gi]),
            .enable_in(enable_q[gi]),
            .flag_q(flags[gi]),
            .gated(gated[gi])
         );
      end
   endgenerate

   // ***************************************
   // Request and read-back
   // ***************************************
   wire global_en = hw_config_reg[hcie_pkg::HWCFG_GLOBAL_IRQ_BIT];
   wire [15:0] rd_word = rd_enable ? enable_q : (rd_status ? {9'h000, flags} : 16'h0000);
   assign irq_d = (|gated) & global_en;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         irq_q <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 16'h0000;
      end else begin
         irq_q <= irq_d;
         rd_valid <= rd_enable | rd_status;
         rd_data <= rd_word;
      end
   end

   // ***************************************
   // Check sequences
   // ***************************************
   // An enable write is its command followed by the data word
   sequence s_enable_cmd;
      cmd_valid && cmd_code == hcie_pkg::CMD_ENABLE_WR;
   endsequence

   sequence s_status_cmd;
      cmd_valid && cmd_code == hcie_pkg::CMD_STATUS_WR;
   endsequence

   sequence s_data_word;
      wr_valid && !cmd_valid;
   endsequence

   sequence s_enable_write;
      s_enable_cmd ##1 s_data_word;
   endsequence

   sequence s_status_write;
      s_status_cmd ##1 s_data_word;
   endsequence

   // A raised source: flag set, unmasked, global enable on
   sequence s_live_source;
      (|(flags & enable_q[6:0])) && global_en;
   endsequence

   // A set flag with its enable and the global enable on raises the request
   property p_gate(logic flag, logic en);
      @(posedge clk_sys) disable iff (!reset_n)
      flag && en && global_en |=> irq_q;
   endproperty

   // An event sets its own flag on the next edge
   property p_sets(logic ev, logic flag);
      @(posedge clk_sys) disable iff (!reset_n)
      ev |=> flag;
   endproperty

   // ***************************************
   // Reset and command port checks
   // ***************************************
   a_reset_clears: assert property (
      @(posedge clk_sys)
      !reset_n |=> enable_q == hcie_pkg::ENABLE_RESET && !irq_q)
      else $error("enable or request not clear after reset");

   a_cmd_held: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !cmd_valid |=> cmd_q == $past(cmd_q))
      else $error("command changed without a strobe");

   a_enable_seq: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      s_enable_write |=> enable_q == ($past(wr_data) & hcie_pkg::ENABLE_MASK))
      else $error("enable command and data not applied");

   a_enable_write: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      wr_enable |=> enable_q == ($past(wr_data) & hcie_pkg::ENABLE_MASK))
      else $error("enable write lost");

   a_enable_hold: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !wr_enable |=> enable_q == $past(enable_q))
      else $error("enable changed without a write");

   a_enable_read: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      rd_enable && !wr_enable |=> rd_valid && rd_data == $past(enable_q))
      else $error("enable read-back wrong");

   a_rd_enable_valid: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      rd_enable |=> rd_valid)
      else $error("read strobe missing");

   a_status_read: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      rd_status |=> rd_data == {9'h000, $past(flags)})
      else $error("status read-back wrong");

   a_rd_idle: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !(rd_enable || rd_status) |=> !rd_valid)
      else $error("read strobe without a read");

   a_rd_idle_zero: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !rd_valid |-> rd_data == 16'h0000)
      else $error("read data not zero when idle");

   // ***************************************
   // Request checks
   // ***************************************
   a_reserved_zero: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (enable_q & ~hcie_pkg::ENABLE_MASK) == 16'h0000)
      else $error("reserved enable bit set");

   a_masked_quiet: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (flags & enable_q[6:0]) == 7'h00 |=> !irq_q)
      else $error("request from a masked source");

   a_global_off: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !global_en |=> !irq_q)
      else $error("request with global enable off");

   a_irq_needs_global: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      irq_q |-> $past(global_en))
      else $error("request without global enable");

   a_irq_needs_enable: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      irq_q |-> $past(|(flags & enable_q[6:0])))
      else $error("request without enabled flag");

   a_irq_raised: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      s_live_source |=> irq_q)
      else $error("request missing");

   a_irq_drops: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      s_enable_write ##1 (enable_q[6:0] == 7'h00) |=> !irq_q)
      else $error("request stays after all sources masked");

   // Each enable bit gates the flag in the same position
   a_sof_gate: assert property (p_gate(flags[hcie_pkg::BIT_SOF], enable_q[hcie_pkg::BIT_SOF]))
      else $error("start-of-frame request missing");

   a_async_gate: assert property (p_gate(flags[hcie_pkg::BIT_ASYNC], enable_q[hcie_pkg::BIT_ASYNC]))
      else $error("async list request missing");

   a_eot_gate: assert property (p_gate(flags[hcie_pkg::BIT_EOT], enable_q[hcie_pkg::BIT_EOT]))
      else $error("end of transfer request missing");

   a_opreg_gate: assert property (p_gate(flags[hcie_pkg::BIT_OPREG], enable_q[hcie_pkg::BIT_OPREG]))
      else $error("operational register request missing");

   a_susp_gate: assert property (p_gate(flags[hcie_pkg::BIT_SUSP], enable_q[hcie_pkg::BIT_SUSP]))
      else $error("suspended request missing");

   a_clkrdy_gate: assert property (p_gate(flags[hcie_pkg::BIT_CLKRDY], enable_q[hcie_pkg::BIT_CLKRDY]))
      else $error("clock ready request missing");

   // ***************************************
   // Status flag checks
   // ***************************************
   a_flag_sticky: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      flags[hcie_pkg::BIT_EOT] && !wr_status |=> flags[hcie_pkg::BIT_EOT])
      else $error("flag cleared without write");

   a_flags_hold: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !wr_status && events == 7'h00 |=> flags == $past(flags))
      else $error("flags changed without event or clear");

   a_status_clear: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      s_status_write |=> (flags & $past(clear_bits) & ~$past(events)) == 7'h00)
      else $error("status clear not applied");

   a_event_wins: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (|events) |=> (flags & $past(events)) == $past(events))
      else $error("event lost against a clear");

   a_eot_sets: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      end_of_transfer_ext |=> flags[hcie_pkg::BIT_EOT])
      else $error("external end of transfer lost");

   a_bit3_quiet: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !flags[3])
      else $error("reserved flag set");

   // Each event lands in its own flag position
   a_sof_sets: assert property (p_sets(sof_event, flags[hcie_pkg::BIT_SOF]))
      else $error("start-of-frame flag not set");

   a_async_sets: assert property (p_sets(async_list_event, flags[hcie_pkg::BIT_ASYNC]))
      else $error("async list flag not set");

   a_eot_int_sets: assert property (p_sets(end_of_transfer_int, flags[hcie_pkg::BIT_EOT]))
      else $error("internal end of transfer lost");

   a_opreg_sets: assert property (p_sets(op_reg_event, flags[hcie_pkg::BIT_OPREG]))
      else $error("operational register flag not set");

   a_susp_sets: assert property (p_sets(suspended_event, flags[hcie_pkg::BIT_SUSP]))
      else $error("suspended flag not set");

   a_clkrdy_sets: assert property (p_sets(clock_ready_event, flags[hcie_pkg::BIT_CLKRDY]))
      else $error("clock ready flag not set");
endmodule // hcie_irq_enable

/* File: hcie_pkg.sv */
// Package of constants for the processor interrupt enable block
// Functional notes
// - The enable register is read with command 25 hex and written with command A5 hex.
// - Enable bits 6 to 0 line up one for one with the status flags they gate.
// - The request pin is raised only for a set flag whose enable is set while the global enable is on.
// - Power-on reset clears every enable bit so no request appears until software enables one.
// - An enable bit at one unmasks its source and at zero keeps it masked.
// - Bit 5 enables the suspended event and bit 6 the clock-ready event, both clear at reset.
// - Bit 4 enables the operational register set event.
// - Bit 2 enables the end-of-transfer event.
// - Bit 1 enables the asynchronous list event.
// - Bit 0 enables the start-of-frame event.
// - Bits 15 to 7 and bit 3 are reserved, hold no enable and read zero.
// - Status flags stay set after a read and clear only by writing one through command A4 hex.
// - The end-of-transfer flag is set by an internal or an external end of transfer.
package hcie_pkg;
   // ***************************************
   // Command codes
   // ***************************************
   localparam logic [7:0] CMD_ENABLE_RD = 8'h25;
   localparam logic [7:0] CMD_ENABLE_WR = 8'hA5;
   localparam logic [7:0] CMD_STATUS_RD = 8'h24;
   localparam logic [7:0] CMD_STATUS_WR = 8'hA4;
   // ***************************************
   // Field layout
   // ***************************************
   localparam int BIT_SOF = 0;
   localparam int BIT_ASYNC = 1;
   localparam int BIT_EOT = 2;
   localparam int BIT_OPREG = 4;
   localparam int BIT_SUSP = 5;
   localparam int BIT_CLKRDY = 6;
   localparam int NUM_SRC = 7;
   localparam logic [15:0] ENABLE_MASK = 16'h0077;
   localparam logic [15:0] ENABLE_RESET = 16'h0000;
   localparam logic [6:0] STATUS_RESET = 7'h00;
   localparam int HWCFG_GLOBAL_IRQ_BIT = 0;
endpackage

/* File: tb.sv */
// Self-checking testbench for the processor interrupt enable block
module tb;
   timeunit 1ns / 1ps;
   logic clk_sys = 1'b0, reset_n = 1'b0, cmd_valid, wr_valid, rd_valid, irq_q;
   logic [6:0] ev = 7'h00;
   logic [7:0] cmd_code;
   logic [15:0] hw_config_reg = 16'h0001, wr_data, rd_data, q;
   int err_total = 0, num_checks = 0, cyc = 0;
   always #4 clk_sys = ~clk_sys;
   hcie_irq_enable i_hcie_irq_enable (.*, .clock_ready_event(ev[6]), .suspended_event(ev[5]),
      .op_reg_event(ev[4]), .end_of_transfer_int(ev[2]), .end_of_transfer_ext(ev[3]),
      .async_list_event(ev[1]), .sof_event(ev[0]));
   hcie_host i_hcie_host (.*);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      err_total += int'(got !== exp);
      if (got !== exp) $display("MISMATCH %0t got %h exp %h", $time, got, exp);
   endtask
   task automatic t_reg;
      i_hcie_host.xfer(8'h25, 16'h0000, q);
      chk({15'h0000, rd_valid}, 16'h0001);
      chk(q, 16'h0000);
      i_hcie_host.xfer(8'ha5, 16'hffff, q);
      i_hcie_host.xfer(8'h25, 16'h0000, q);
      chk(q, 16'h0077);
   endtask
   task automatic t_source(input int e, input int b);
      i_hcie_host.xfer(8'ha5, 16'h0077 & ~(16'h0001 << b), q);
      ev[e] = 1'b1;
      @(negedge clk_sys);
      ev[e] = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk({15'h0000, irq_q}, 16'h0000);
      i_hcie_host.xfer(8'ha5, 16'h0001 << b, q);
      chk({15'h0000, irq_q}, 16'h0001);
      hw_config_reg = 16'hfffe;
      i_hcie_host.xfer(8'h24, 16'h0000, q);
      chk({15'h0000, irq_q}, 16'h0000);
      i_hcie_host.xfer(8'h24, 16'h0000, q);
      chk(q, 16'h0001 << b);
      hw_config_reg = 16'h0001;
      i_hcie_host.xfer(8'ha4, 16'h0001 << b, q);
      i_hcie_host.xfer(8'h24, 16'h0000, q);
      chk(q, 16'h0000);
   endtask
   task automatic give_verdict(input int hung);
      err_total += hung;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk_sys) if (++cyc == 5000) give_verdict(1);
   initial begin
      repeat (10) @(negedge clk_sys);
      reset_n = 1'b1;
      t_reg();
      for (int e = 0; e < 7; e++) t_source(e, e - (e == 3));
      give_verdict(0);
   end
endmodule // tb
